// *** dv/pss_asserts.sv ***
// Port-level checker for the pump speed supervisor
`timescale 1ns/10ps
`default_nettype none
module pss_asserts
	import pss_pkg::*;
#(
	parameter logic [15:0] PMAX_W = 16'h0064
) (
	// Clock and reset
	input wire logic        CLOCK,
	input wire logic        RSTN,
	// Bus
	input wire logic        HSEL,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	// Drive side
	input wire logic [15:0] SPEED_HZ,
	input wire logic [15:0] POWER_LIMIT_W,
	input wire logic        SWITCHPOINT_OUT,
	input wire logic        BACKING_PUMP,
	input wire logic        ROTATING,
	input wire logic        NOT_ROTATING,
	input wire logic        RUNUP_ERROR
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	// Accepted address phases
	logic       rd_taken;
	logic       wr_taken;
	logic [2:0] since_wr;
	assign rd_taken = HSEL && HREADY && HTRANS[1] && !HWRITE;
	assign wr_taken = HSEL && HREADY && HTRANS[1] && HWRITE;
	// Cycles since the last write, saturating so a long idle stretch stays cheap
	always_ff @(posedge CLOCK) begin
		if (!RSTN || wr_taken)
			since_wr <= 3'h0;
		else if (since_wr != 3'h7)
			since_wr <= since_wr + 3'h1;
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_rot_above_one: assert property (SPEED_HZ > PSS_ROT_HZ |=> ROTATING)
		else $error("rotating flag low above 1 Hz");
	a_still_below_two: assert property (SPEED_HZ < PSS_NOROT_HZ |=> NOT_ROTATING)
		else $error("not rotating flag low below 2 Hz");
	a_rot_flags_split: assert property (!(ROTATING && NOT_ROTATING))
		else $error("both rotation flags high");
	a_limit_under_max: assert property (POWER_LIMIT_W <= PMAX_W)
		else $error("power limit above maximum");
	a_read_one_wait: assert property (rd_taken |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state not exactly one cycle");
	a_write_no_wait: assert property (wr_taken |=> HREADYOUT)
		else $error("write stalled");
	a_rdata_holds: assert property ($changed(HRDATA) |-> $past(rd_taken) || $past(rd_taken, 2))
		else $error("read data changed without a read");
	a_error_sticky: assert property ($fell(RUNUP_ERROR) |-> since_wr < 3'h6)
		else $error("run-up error cleared without a write");
	a_resp_always_okay: assert property (HRESP == 1'b0)
		else $error("error response on the bus");
	// Main scenarios reached
	c_read: cover property (rd_taken);
	c_sp_rise: cover property ($rose(SWITCHPOINT_OUT));
	c_bp_rise: cover property ($rose(BACKING_PUMP));
	c_err_rise: cover property ($rose(RUNUP_ERROR));
endmodule : pss_asserts
bind pss_supervisor pss_asserts #(.PMAX_W(PMAX_W)) u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .HSEL(HSEL),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
	.HRESP(HRESP), .SPEED_HZ(SPEED_HZ), .POWER_LIMIT_W(POWER_LIMIT_W), .SWITCHPOINT_OUT(SWITCHPOINT_OUT),
	.BACKING_PUMP(BACKING_PUMP), .ROTATING(ROTATING), .NOT_ROTATING(NOT_ROTATING), .RUNUP_ERROR(RUNUP_ERROR));
`default_nettype wire

// *** dv/pss_host.sv ***
// Host controller model: single-word bus master writing parameters, reading status
`timescale 1ns/10ps
`default_nettype none
module pss_host
	import pss_pkg::*;
(
	// Clock
	input wire logic         CLOCK,
	// Master side of the bus
	output var logic        HSEL,
	output var logic [31:0] HADDR,
	output var logic [1:0]  HTRANS,
	output var logic        HWRITE,
	output var logic [2:0]  HSIZE,
	output var logic [31:0] HWDATA,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA
);
	initial begin
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
	end
	// One transfer; stale write data is inverted so no phase can reuse it by luck
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		HSEL <= 1'b1;
		HADDR <= {24'h0, a};
		HTRANS <= 2'h2;
		HWRITE <= wr;
		HWDATA <= ~HWDATA;
		@(posedge CLOCK);
		while (!HREADY) @(posedge CLOCK);
		HTRANS <= 2'h0;
		HWDATA <= d;
		@(posedge CLOCK);
		while (!HREADY) @(posedge CLOCK);
		q = HRDATA;
	endtask : xfer
	// Host-side parameter writes, nominal speed confirmation among them
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask : rd
endmodule : pss_host
`default_nettype wire

// *** dv/pump_speed_supervisor_bench.sv ***
// Self-checking bench for the pump speed supervisor
`timescale 1ns/10ps
`default_nettype none
module pump_speed_supervisor_bench;
	import pss_pkg::*;
	logic CLOCK = 1'b0, RSTN = 1'b0, HSEL, HWRITE, HREADYOUT, HRESP, SPO, BP, ROT, NROT, ATT, WARN, ERR;
	logic [31:0] HADDR, HWDATA, HRDATA, v;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	logic [15:0] SPEED_HZ = 16'h0, POWER_W = 16'h0, CMD, LIM;
	int n_errors = 0, checks = 0;
	always #20 CLOCK = ~CLOCK;
	// Short counts keep the run small
	pss_supervisor #(.SEC_CYC(10), .BP_CYC(20), .DERATE_CYC(4)) u_dut (.CLOCK(CLOCK), .RSTN(RSTN),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SPEED_HZ(SPEED_HZ),
		.POWER_W(POWER_W), .SPEED_CMD_HZ(CMD), .POWER_LIMIT_W(LIM), .SWITCHPOINT_OUT(SPO), .BACKING_PUMP(BP),
		.ROTATING(ROT), .NOT_ROTATING(NROT), .TARGET_SPEED_ATTAINED(ATT), .MIN_SPEED_WARNING(WARN),
		.RUNUP_ERROR(ERR));
	pss_host u_host (.CLOCK(CLOCK), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic finish_test;
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		u_host.rd(a, v);
		chk(v, exp);
	endtask : rd_chk
	// Drive a speed and let the registered flags follow
	task automatic spd(input logic [15:0] s);
		SPEED_HZ <= s;
		repeat (3) @(posedge CLOCK);
	endtask : spd
	task automatic pwr(input logic [15:0] p);
		POWER_W <= p;
		repeat (3) @(posedge CLOCK);
	endtask : pwr
	// Hang guard, far above the expected run length
	initial begin
		repeat (5000) @(posedge CLOCK);
		n_errors++;
		finish_test();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge CLOCK);
		RSTN <= 1'b1;
		rd_chk(PSS_NOMINAL_OFS, 32'h05DC);
		rd_chk(PSS_STANDBY_OFS, 32'h029B);
		rd_chk(8'h30, 32'h0);
		u_host.wr(PSS_NOMINAL_OFS, 32'h05DC);
		u_host.wr(PSS_RUNUP_OFS, 32'h2);
		u_host.wr(PSS_PWRPCT_OFS, 32'h01F4);
		u_host.wr(PSS_CTRL_OFS, 32'h01);
		spd(16'h0);
		chk(BP, 1'b1);
		chk(LIM, 16'h0032);
		chk(ERR, 1'b0);
		rd_chk(PSS_TARGET_OFS, 32'h05DC05DC);
		repeat (40) @(posedge CLOCK);
		chk(ERR, 1'b1);
		// Each gas mode after a completed run-up
		SPEED_HZ <= 16'h05DC;
		for (int g = 0; g < 3; g++) begin
			u_host.wr(PSS_CTRL_OFS, 32'h0);
			u_host.wr(PSS_CTRL_OFS, 32'h01 | (g << 4));
			spd(16'h05DC);
			chk(LIM, 16'h0028 + 16'(10 * g));
			chk(ATT, 1'b1);
		end
		chk(ERR, 1'b0);
		spd(16'h05DB);
		chk(ATT, 1'b0);
		// Overpower must pull the command down, then it recovers
		pwr(16'h0046);
		repeat (20) @(posedge CLOCK);
		u_host.rd(PSS_TARGET_OFS, v);
		chk(v[31:16] < 16'h05DC, 1'b1);
		pwr(16'h0);
		repeat (40) @(posedge CLOCK);
		// Single switchpoint at 80 % of 1500
		spd(16'h04B1);
		chk(SPO, 1'b1);
		u_host.rd(PSS_STATUS_OFS, v);
		chk(v[1], 1'b1);
		spd(16'h04B0);
		chk(SPO, 1'b1);
		spd(16'h04AF);
		chk(SPO, 1'b0);
		// Two-point selection: station on keeps the first threshold
		u_host.wr(PSS_SP2_OFS, 32'h01F4);
		u_host.wr(PSS_CTRL_OFS, 32'h29);
		spd(16'h044C);
		chk(SPO, 1'b0);
		// Station off hands the threshold to the second switchpoint
		u_host.wr(PSS_CTRL_OFS, 32'h28);
		spd(16'h044C);
		chk(SPO, 1'b1);
		// Standby target
		u_host.wr(PSS_CTRL_OFS, 32'h2B);
		rd_chk(PSS_TARGET_OFS, 32'h03E803E8);
		spd(16'h03E8);
		chk(ATT, 1'b1);
		spd(16'h03E7);
		chk(ATT, 1'b0);
		// Setting mode wins over standby; switchpoint scales
		u_host.wr(PSS_SETMODE_OFS, 32'h01F4);
		u_host.wr(PSS_CTRL_OFS, 32'h2F);
		rd_chk(PSS_TARGET_OFS, 32'h02EE02EE);
		spd(16'h0259);
		chk(SPO, 1'b1);
		chk(WARN, 1'b0);
		u_host.wr(PSS_SETMODE_OFS, 32'h0064);
		rd_chk(PSS_TARGET_OFS, 32'h01770177);
		chk(WARN, 1'b1);
		// Rotation indications around 1 and 2 Hz
		for (int s = 0; s < 4; s++) begin
			spd(16'(s));
			chk(ROT, s > 1);
			chk(NROT, s < 2);
		end
		// Delayed switch-on at 6 Hz
		u_host.wr(PSS_CTRL_OFS, 32'h81);
		spd(16'h6);
		chk(BP, 1'b0);
		spd(16'h7);
		chk(BP, 1'b1);
		// Intermittent thresholds 20 W on, 10 W off
		u_host.wr(PSS_CTRL_OFS, 32'h41);
		pwr(16'h5);
		chk(BP, 1'b0);
		pwr(16'h14);
		chk(BP, 1'b1);
		pwr(16'hF);
		chk(BP, 1'b1);
		pwr(16'hA);
		chk(BP, 1'b0);
		// Delayed intermittent: condition must hold for the full delay
		u_host.wr(PSS_CTRL_OFS, 32'hC1);
		pwr(16'h5);
		repeat (30) @(posedge CLOCK);
		pwr(16'h14);
		repeat (12) @(posedge CLOCK);
		chk(BP, 1'b0);
		repeat (15) @(posedge CLOCK);
		chk(BP, 1'b1);
		finish_test();
	end
endmodule : pump_speed_supervisor_bench
`default_nettype wire

// *** hdl/pss_pkg.sv ***
// Shared constants for the pump speed supervisor
package pss_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] PSS_CTRL_OFS    = 8'h00;
	localparam logic [7:0] PSS_NOMINAL_OFS = 8'h04;
	localparam logic [7:0] PSS_SETMODE_OFS = 8'h08;
	localparam logic [7:0] PSS_STANDBY_OFS = 8'h0C;
	localparam logic [7:0] PSS_SP1_OFS     = 8'h10;
	localparam logic [7:0] PSS_SP2_OFS     = 8'h14;
	localparam logic [7:0] PSS_PWRPCT_OFS  = 8'h18;
	localparam logic [7:0] PSS_RUNUP_OFS   = 8'h1C;
	localparam logic [7:0] PSS_BPON_OFS    = 8'h20;
	localparam logic [7:0] PSS_BPOFF_OFS   = 8'h24;
	localparam logic [7:0] PSS_STATUS_OFS  = 8'h28;
	localparam logic [7:0] PSS_TARGET_OFS  = 8'h2C;
	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int PSS_CTRL_STATION = 0;
	localparam int PSS_CTRL_STANDBY = 1;
	localparam int PSS_CTRL_SETMODE = 2;
	localparam int PSS_CTRL_SPSEL   = 3;
	localparam int PSS_CTRL_GAS_LO  = 4;
	localparam int PSS_CTRL_BPM_LO  = 6;
	// ----------------------------------------------------------------
	// Reset values (percentages in tenths of a percent)
	// ----------------------------------------------------------------
	localparam logic [15:0] PSS_NOMINAL_RST = 16'h05DC; // 1500 Hz
	localparam logic [9:0]  PSS_SETMODE_RST = 10'h3E8;  // 100.0 %
	localparam logic [9:0]  PSS_STANDBY_RST = 10'h29B;  // 66.7 %
	localparam logic [9:0]  PSS_SP1_RST     = 10'h320;  // 80.0 %
	localparam logic [9:0]  PSS_SP2_RST     = 10'h320;
	localparam logic [9:0]  PSS_PWRPCT_RST  = 10'h3E8;  // 100.0 %
	localparam logic [15:0] PSS_RUNUP_RST   = 16'h01E0; // seconds
	localparam logic [15:0] PSS_BPON_RST    = 16'h0014; // watts
	localparam logic [15:0] PSS_BPOFF_RST   = 16'h000A;
	localparam logic [25:0] PSS_PERMILLE    = 26'h00003E8;
	// ----------------------------------------------------------------
	// Fixed speed thresholds and timing
	// ----------------------------------------------------------------
	localparam logic [15:0] PSS_ROT_HZ     = 16'h0001;
	localparam logic [15:0] PSS_NOROT_HZ   = 16'h0002;
	localparam logic [15:0] PSS_BP_DLY_HZ  = 16'h0006;
	localparam int          PSS_CLK_HZ     = 25000000;
	localparam int          PSS_BP_HOLD_S  = 8;
	localparam int          PSS_DERATE_US  = 1000;
	localparam int          PSS_SEC_CYC    = PSS_CLK_HZ;
	localparam int          PSS_BP_CYC     = PSS_BP_HOLD_S * PSS_CLK_HZ;
	localparam int          PSS_DERATE_CYC = PSS_DERATE_US * (PSS_CLK_HZ / 1000000);
	// ----------------------------------------------------------------
	// Gas modes and backing pump modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PSS_GAS_HEAVY, PSS_GAS_LIGHT, PSS_GAS_HELIUM, PSS_GAS_RSV} pss_gas_t;
	typedef enum logic [1:0] {PSS_BP_CONT, PSS_BP_INTER, PSS_BP_DELAY, PSS_BP_DINTER} pss_bpm_t;
endpackage : pss_pkg

// *** hdl/pss_supervisor.sv ***
// Pump speed supervisor: speed targets, power limit, switchpoints, backing pump
//
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module pss_supervisor
	import pss_pkg::*;
#(
	parameter int          SEC_CYC     = PSS_SEC_CYC,
	parameter int          BP_CYC      = PSS_BP_CYC,
	parameter int          DERATE_CYC  = PSS_DERATE_CYC,
	parameter logic [15:0] PMAX_W      = 16'h0064,
	parameter logic [15:0] PGAS_HEAVY  = 16'h0028,
	parameter logic [15:0] PGAS_LIGHT  = 16'h0032,
	parameter logic [15:0] PGAS_HELIUM = 16'h003C,
	parameter logic [9:0]  MIN_PCT     = 10'h0FA
) (
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RSTN,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// Drive measurements
	input  wire logic [15:0] SPEED_HZ,
	input  wire logic [15:0] POWER_W,
	// Drive commands and accessory outputs
	output logic      [15:0] SPEED_CMD_HZ,
	output logic      [15:0] POWER_LIMIT_W,
	output logic             SWITCHPOINT_OUT,
	output logic             BACKING_PUMP,
	output logic             ROTATING,
	output logic             NOT_ROTATING,
	output logic             TARGET_SPEED_ATTAINED,
	output logic             MIN_SPEED_WARNING,
	output logic             RUNUP_ERROR
);
	// ----------------------------------------------------------------
	// Registers written by the host
	// ----------------------------------------------------------------
	logic [7:0]  ctrl;
	logic [15:0] nominal;
	logic [9:0]  setmode_pct;
	logic [9:0]  standby_pct;
	logic [9:0]  sp1_pct;
	logic [9:0]  sp2_pct;
	logic [9:0]  power_pct;
	logic [15:0] runup_time_limit;
	logic [15:0] bp_on_w;
	logic [15:0] bp_off_w;
	// Bus phase state
	logic        wr_pend;
	logic        rd_pend;
	logic [7:0]  addr_q;
	logic        access;
	// Internal state
	logic        station;
	logic        runup_done;
	logic [31:0] sec_cnt;
	logic [15:0] runup_secs;
	logic [31:0] der_cnt;
	logic [15:0] derate;
	logic [31:0] bp_cnt;
	logic        bp_inter;
	// Combinational terms
	logic [9:0]  req_pct;
	logic [9:0]  eff_pct;
	logic        below_min;
	logic [15:0] target_hz;
	logic [15:0] sw_hz;
	logic [9:0]  sw_pct;
	logic [15:0] gas_limit;
	logic [15:0] runup_limit;
	logic        over_power;
	logic        bp_want_on;
	logic        bp_want_off;
	logic [31:0] next_rdata;

	assign station = ctrl[PSS_CTRL_STATION];

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	assign access    = HSEL && HREADY && HTRANS[1];
	assign HREADYOUT = !rd_pend;
	assign HRESP     = 1'b0;

	// Address phase capture; reads take one wait state so data leave a flop
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q  <= 8'h00;
		end else begin
			if (rd_pend) begin
				rd_pend <= 1'b0;
			end else begin
				wr_pend <= access && HWRITE;
				rd_pend <= access && !HWRITE;
				if (access) begin
					addr_q <= HADDR[7:0];
				end
			end
		end
	end

	// Host register writes; unmapped offsets are ignored
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			ctrl             <= 8'h00;
			nominal          <= PSS_NOMINAL_RST;
			setmode_pct      <= PSS_SETMODE_RST;
			standby_pct      <= PSS_STANDBY_RST;
			sp1_pct          <= PSS_SP1_RST;
			sp2_pct          <= PSS_SP2_RST;
			power_pct        <= PSS_PWRPCT_RST;
			runup_time_limit <= PSS_RUNUP_RST;
			bp_on_w          <= PSS_BPON_RST;
			bp_off_w         <= PSS_BPOFF_RST;
		end else if (wr_pend) begin
			case (addr_q)
				PSS_CTRL_OFS:    ctrl             <= HWDATA[7:0];
				PSS_NOMINAL_OFS: nominal          <= HWDATA[15:0];
				PSS_SETMODE_OFS: setmode_pct      <= HWDATA[9:0];
				PSS_STANDBY_OFS: standby_pct      <= HWDATA[9:0];
				PSS_SP1_OFS:     sp1_pct          <= HWDATA[9:0];
				PSS_SP2_OFS:     sp2_pct          <= HWDATA[9:0];
				PSS_PWRPCT_OFS:  power_pct        <= HWDATA[9:0];
				PSS_RUNUP_OFS:   runup_time_limit <= HWDATA[15:0];
				PSS_BPON_OFS:    bp_on_w          <= HWDATA[15:0];
				PSS_BPOFF_OFS:   bp_off_w         <= HWDATA[15:0];
				default: ;
			endcase
		end
	end

	// Read multiplexer; unmapped offsets read zero
	always_comb begin
		next_rdata = 32'h00000000;
		case (addr_q)
			PSS_CTRL_OFS:    next_rdata[7:0]  = ctrl;
			PSS_NOMINAL_OFS: next_rdata[15:0] = nominal;
			PSS_SETMODE_OFS: next_rdata[9:0]  = setmode_pct;
			PSS_STANDBY_OFS: next_rdata[9:0]  = standby_pct;
			PSS_SP1_OFS:     next_rdata[9:0]  = sp1_pct;
			PSS_SP2_OFS:     next_rdata[9:0]  = sp2_pct;
			PSS_PWRPCT_OFS:  next_rdata[9:0]  = power_pct;
			PSS_RUNUP_OFS:   next_rdata[15:0] = runup_time_limit;
			PSS_BPON_OFS:    next_rdata[15:0] = bp_on_w;
			PSS_BPOFF_OFS:   next_rdata[15:0] = bp_off_w;
			PSS_STATUS_OFS:  next_rdata[7:0]  = {NOT_ROTATING, ROTATING, BACKING_PUMP, RUNUP_ERROR,
				MIN_SPEED_WARNING, TARGET_SPEED_ATTAINED, SWITCHPOINT_OUT, runup_done};
			PSS_TARGET_OFS:  next_rdata       = {SPEED_CMD_HZ, target_hz};
			default: ;
		endcase
	end

	// Read data register, loaded during the wait state
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			HRDATA <= 32'h00000000;
		end else if (rd_pend) begin
			HRDATA <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Speed target selection
	// ----------------------------------------------------------------
	// Setting mode wins over standby; plain nominal otherwise
	always_comb begin
		if (ctrl[PSS_CTRL_SETMODE]) begin
			req_pct = setmode_pct;
		end else if (ctrl[PSS_CTRL_STANDBY]) begin
			req_pct = standby_pct;
		end else begin
			req_pct = PSS_SETMODE_RST;
		end
	end

	// Reduced targets under the pump minimum are pulled up to it
	assign below_min = (ctrl[PSS_CTRL_SETMODE] || ctrl[PSS_CTRL_STANDBY]) && (req_pct < MIN_PCT);
	assign eff_pct   = below_min ? MIN_PCT : req_pct;
	// The selected speed percentage scales the confirmed nominal speed
	assign target_hz = 16'((26'(nominal) * 26'(eff_pct)) / PSS_PERMILLE);

	// Switchpoint source; the threshold follows the active target
	assign sw_pct = (ctrl[PSS_CTRL_SPSEL] && !station) ? sp2_pct : sp1_pct;
	assign sw_hz  = 16'((26'(target_hz) * 26'(sw_pct)) / PSS_PERMILLE);

	// ----------------------------------------------------------------
	// Speed status flags
	// ----------------------------------------------------------------
	// The switchpoint flag holds its state while speed sits on the threshold
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			SWITCHPOINT_OUT       <= 1'b0;
			TARGET_SPEED_ATTAINED <= 1'b0;
			MIN_SPEED_WARNING     <= 1'b0;
			ROTATING              <= 1'b0;
			NOT_ROTATING          <= 1'b1;
		end else begin
			if (SPEED_HZ > sw_hz) begin
				SWITCHPOINT_OUT <= 1'b1;
			end else if (SPEED_HZ < sw_hz) begin
				SWITCHPOINT_OUT <= 1'b0;
			end
			if (SPEED_HZ >= target_hz) begin
				TARGET_SPEED_ATTAINED <= 1'b1;
			end else begin
				TARGET_SPEED_ATTAINED <= 1'b0;
			end
			MIN_SPEED_WARNING <= below_min;
			ROTATING          <= SPEED_HZ > PSS_ROT_HZ;
			NOT_ROTATING      <= SPEED_HZ < PSS_NOROT_HZ;
		end
	end

	// ----------------------------------------------------------------
	// Power limit and run-up supervision
	// ----------------------------------------------------------------
	always_comb begin
		case (pss_gas_t'(ctrl[PSS_CTRL_GAS_LO +: 2]))
			PSS_GAS_HEAVY:  gas_limit = PGAS_HEAVY;
			PSS_GAS_LIGHT:  gas_limit = PGAS_LIGHT;
			PSS_GAS_HELIUM: gas_limit = PGAS_HELIUM;
			default:        gas_limit = PGAS_HEAVY;
		endcase
	end

	// Run-up power is the maximum scaled by the power percentage
	assign runup_limit = 16'((26'(PMAX_W) * 26'(power_pct)) / PSS_PERMILLE);

	// Limit switches to the gas curve once the target was reached
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			POWER_LIMIT_W <= 16'h0000;
		end else begin
			POWER_LIMIT_W <= runup_done ? gas_limit : runup_limit;
		end
	end

	assign over_power = runup_done && (POWER_W > gas_limit);

	// Run-up ends at first attainment and restarts with the station
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			runup_done <= 1'b0;
		end else if (!station) begin
			runup_done <= 1'b0;
		end else if (TARGET_SPEED_ATTAINED) begin
			runup_done <= 1'b1;
		end
	end

	// Seconds counter for the run-up watchdog; error holds until station off
	always_ff @(posedge CLOCK) begin
		if (!RSTN || !station || runup_done) begin
			sec_cnt    <= 32'h00000000;
			runup_secs <= 16'h0000;
		end else if (sec_cnt == 32'(SEC_CYC - 1)) begin
			sec_cnt    <= 32'h00000000;
			runup_secs <= runup_secs + 16'h0001;
		end else begin
			sec_cnt <= sec_cnt + 32'h00000001;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RSTN || !station) begin
			RUNUP_ERROR <= 1'b0;
		end else if (!runup_done && (runup_secs >= runup_time_limit)) begin
			RUNUP_ERROR <= 1'b1;
		end
	end

	// Speed derating: step down one hertz per tick while power is too high
	always_ff @(posedge CLOCK) begin
		if (!RSTN || !station) begin
			der_cnt <= 32'h00000000;
			derate  <= 16'h0000;
		end else if (der_cnt == 32'(DERATE_CYC - 1)) begin
			der_cnt <= 32'h00000000;
			if (over_power && (derate < target_hz)) begin
				derate <= derate + 16'h0001;
			end else if (!over_power && (derate != 16'h0000)) begin
				derate <= derate - 16'h0001;
			end
		end else begin
			der_cnt <= der_cnt + 32'h00000001;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			SPEED_CMD_HZ <= 16'h0000;
		end else begin
			SPEED_CMD_HZ <= station ? 16'(target_hz - derate) : 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Backing pump control
	// ----------------------------------------------------------------
	// Intermittent hysteresis; the delayed variant waits for a steady request
	assign bp_want_on  = !bp_inter && (POWER_W >= bp_on_w);
	assign bp_want_off = bp_inter && (POWER_W <= bp_off_w);

	always_ff @(posedge CLOCK) begin
		if (!RSTN || !station) begin
			bp_inter <= 1'b0;
			bp_cnt   <= 32'h00000000;
		end else if (!(bp_want_on || bp_want_off)) begin
			bp_cnt <= 32'h00000000;
		end else if (ctrl[PSS_CTRL_BPM_LO +: 2] != 2'(PSS_BP_DINTER)) begin
			bp_inter <= !bp_inter;
			bp_cnt   <= 32'h00000000;
		end else if (bp_cnt == 32'(BP_CYC - 1)) begin
			bp_inter <= !bp_inter;
			bp_cnt   <= 32'h00000000;
		end else begin
			bp_cnt <= bp_cnt + 32'h00000001;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RSTN || !station) begin
			BACKING_PUMP <= 1'b0;
		end else begin
			case (pss_bpm_t'(ctrl[PSS_CTRL_BPM_LO +: 2]))
				PSS_BP_CONT:   BACKING_PUMP <= 1'b1;
				PSS_BP_INTER:  BACKING_PUMP <= bp_inter;
				PSS_BP_DELAY:  BACKING_PUMP <= SPEED_HZ > PSS_BP_DLY_HZ;
				PSS_BP_DINTER: BACKING_PUMP <= bp_inter;
				default:       BACKING_PUMP <= 1'b0;
			endcase
		end
	end
endmodule : pss_supervisor
`default_nettype wire
